// [rtl/ctc_pkg.sv]
// constants and carriers for the converter trim configuration bank
package ctc_pkg;
   localparam logic [7:0] CMD_OFFSET = 8'hd4;
   localparam logic [7:0] CMD_LOCKOUT = 8'hd6;
   localparam logic [7:0] CMD_PGTRK = 8'hd7;
   localparam logic [7:0] CMD_IDENT = 8'hfc;
   // writable masks per register
   localparam logic [7:0] OFFSET_MASK = 8'he0;
   localparam logic [7:0] LOCKOUT_MASK = 8'h07;
   localparam logic [7:0] PGTRK_MASK = 8'hdf;
   // reset values
   localparam logic [7:0] OFFSET_RST = 8'h80;
   localparam logic [7:0] LOCKOUT_RST = 8'h05;
   localparam logic [7:0] PGTRK_RST = 8'h8f;
   // field positions
   localparam int OFS_SEL_BIT = 7;
   localparam int OFS_TRIM_LSB = 5;
   localparam int LOCK_HI_BIT = 2;
   localparam int PG_WIN_BIT = 7;
   localparam int SPARE_BIT = 6;
   localparam int TRK_GATE_BIT = 4;
   localparam int LOCK_LSB = 0;
   localparam int TRK_TGT_LSB = 0;
   // identity, values arbitrary
   localparam logic [11:0] IDENT_CODE = 12'h5a5;
   localparam logic [3:0] REV_CODE = 4'h1;
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] cmd;
      logic [7:0] wdata;
   } ctc_req_s;
   typedef struct packed {
      logic offset_scheme_select;
      logic [1:0] offset_trim_code;
      logic [2:0] bias_lockout_level;
      logic power_good_window_select;
      logic spare_output;
      logic track_gate_option;
      logic [3:0] track_target_code;
   } ctc_cfg_s;
endpackage

// [rtl/ctc_regs.sv]
// converter trim configuration register bank
`timescale 1ns/1ns
module ctc_regs (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic clk_en,
   input wire ctc_pkg::ctc_req_s req,
   input wire logic tracking_input_ok,
   input wire logic switch_request,
   output logic [15:0] rdata,
   output logic rvalid,
   output ctc_pkg::ctc_cfg_s cfg,
   output logic [2:0] trim_mv_steps,
   output logic lockout_high,
   output logic switch_enable
);
   logic [7:0] offset_reg, lockout_reg, pgtrk_reg;
   logic [7:0] offset_next, lockout_next, pgtrk_next;
   logic tok_meta_reg, tok_sync_reg;
   logic hit_ofs, hit_lock, hit_pg, hit_id;
   logic [15:0] rd_mux;
   logic gate_ok;
   logic hit_any;
   ctc_pkg::ctc_cfg_s cfg_next;
   logic [2:0] trim_next;
   logic lockout_high_next;

   // masked merge: writable bits from the host, reserved bits keep their stored zero
   function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] wd,
                                        input logic [7:0] mask);
      merge = (wd & mask) | (old & ~mask);
   endfunction

   // field split of the setting registers, shared by reset and update
   function automatic ctc_pkg::ctc_cfg_s cfg_of(input logic [7:0] ofs, input logic [7:0] lock,
                                               input logic [7:0] pg);
      ctc_pkg::ctc_cfg_s c;
      c = '0;
      c.offset_scheme_select = ofs[ctc_pkg::OFS_SEL_BIT];
      c.offset_trim_code = ofs[ctc_pkg::OFS_TRIM_LSB +: 2];
      c.bias_lockout_level = lock[ctc_pkg::LOCK_LSB +: 3];
      c.power_good_window_select = pg[ctc_pkg::PG_WIN_BIT];
      c.spare_output = pg[ctc_pkg::SPARE_BIT];
      c.track_gate_option = pg[ctc_pkg::TRK_GATE_BIT];
      c.track_target_code = pg[ctc_pkg::TRK_TGT_LSB +: 4];
      return c;
   endfunction

   // trim in mV, forced off in automatic scheme where the manual code is unused
   function automatic logic [2:0] trim_of(input logic [7:0] ofs);
      trim_of = ofs[ctc_pkg::OFS_SEL_BIT] ? 3'h0 :
                {ofs[ctc_pkg::OFS_TRIM_LSB +: 2], 1'b0};
   endfunction

   // command decode
   assign hit_ofs = req.cmd == ctc_pkg::CMD_OFFSET;
   assign hit_lock = req.cmd == ctc_pkg::CMD_LOCKOUT;
   assign hit_pg = req.cmd == ctc_pkg::CMD_PGTRK;
   assign hit_id = req.cmd == ctc_pkg::CMD_IDENT;
   assign offset_next = (req.wr && hit_ofs) ?
      merge(offset_reg, req.wdata, ctc_pkg::OFFSET_MASK) : offset_reg;
   assign lockout_next = (req.wr && hit_lock) ?
      merge(lockout_reg, req.wdata, ctc_pkg::LOCKOUT_MASK) : lockout_reg;
   assign pgtrk_next = (req.wr && hit_pg) ?
      merge(pgtrk_reg, req.wdata, ctc_pkg::PGTRK_MASK) : pgtrk_reg;
   // identification word is read only; unmapped reads give zero
   assign rd_mux = hit_ofs ? {8'h00, offset_reg} :
                   hit_lock ? {8'h00, lockout_reg} :
                   hit_pg ? {8'h00, pgtrk_reg} :
                   hit_id ? {ctc_pkg::IDENT_CODE, ctc_pkg::REV_CODE} : 16'h0000;
   // gate ignores tracking level when option set
   assign gate_ok = pgtrk_reg[ctc_pkg::TRK_GATE_BIT] | tok_sync_reg;
   // any mapped command, used by the checks below
   assign hit_any = hit_ofs | hit_lock | hit_pg | hit_id;
   // outputs load from next values, so they never lag the stored bits
   assign cfg_next = cfg_of(offset_next, lockout_next, pgtrk_next);
   assign trim_next = trim_of(offset_next);
   assign lockout_high_next = ~lockout_next[ctc_pkg::LOCK_HI_BIT];

   // register storage, defaults at reset
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         offset_reg <= ctc_pkg::OFFSET_RST;
         lockout_reg <= ctc_pkg::LOCKOUT_RST;
         pgtrk_reg <= ctc_pkg::PGTRK_RST;
      end else if (clk_en) begin
         offset_reg <= offset_next;
         lockout_reg <= lockout_next;
         pgtrk_reg <= pgtrk_next;
      end
   end

   // tracking ok comes from analog, two-stage sync
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         tok_meta_reg <= 1'b0;
         tok_sync_reg <= 1'b0;
      end else if (clk_en) begin
         tok_meta_reg <= tracking_input_ok;
         tok_sync_reg <= tok_meta_reg;
      end
   end

   // registered outputs, loaded together with the registers they mirror
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rdata <= 16'h0000;
         rvalid <= 1'b0;
         cfg <= cfg_of(ctc_pkg::OFFSET_RST, ctc_pkg::LOCKOUT_RST, ctc_pkg::PGTRK_RST);
         trim_mv_steps <= trim_of(ctc_pkg::OFFSET_RST);
         lockout_high <= ~ctc_pkg::LOCKOUT_RST[ctc_pkg::LOCK_HI_BIT];
         switch_enable <= 1'b0;
      end else if (clk_en) begin
         rdata <= req.rd ? rd_mux : rdata;
         rvalid <= req.rd;
         cfg <= cfg_next;
         trim_mv_steps <= trim_next;
         lockout_high <= lockout_high_next;
         switch_enable <= switch_request & gate_ok;
      end
   end

   // spare output equals the stored bit in every cycle
   spare_follow_a: assert property (@(posedge ref_clk) disable iff (rst)
      cfg.spare_output == pgtrk_reg[ctc_pkg::SPARE_BIT])
      else $error("spare output differs from stored bit");
   // switching blocked without tracking ok when gated
   track_gate_a: assert property (@(posedge ref_clk) disable iff (rst)
      switch_enable |-> ($past(pgtrk_reg[ctc_pkg::TRK_GATE_BIT]) || $past(tok_sync_reg)))
      else $error("switching enabled without tracking ok");
   // reserved bits stay zero
   reserved_zero_a: assert property (@(posedge ref_clk) disable iff (rst)
      (offset_reg & ~ctc_pkg::OFFSET_MASK) == 8'h00 &&
      (lockout_reg & ~ctc_pkg::LOCKOUT_MASK) == 8'h00 &&
      (pgtrk_reg & ~ctc_pkg::PGTRK_MASK) == 8'h00)
      else $error("reserved bit set");
   // trim only applies in manual scheme
   trim_manual_a: assert property (@(posedge ref_clk) disable iff (rst)
      offset_reg[ctc_pkg::OFS_SEL_BIT] |-> trim_mv_steps == 3'h0)
      else $error("trim active in automatic scheme");
   // write to offset lands next cycle
   offset_write_a: assert property (@(posedge ref_clk) disable iff (rst)
      (clk_en && req.wr && hit_ofs) |=>
         offset_reg == ($past(req.wdata) & ctc_pkg::OFFSET_MASK))
      else $error("offset write lost");
   // identification read answer
   ident_read_a: assert property (@(posedge ref_clk) disable iff (rst)
      (clk_en && req.rd && hit_id) |=>
         rvalid && rdata == {ctc_pkg::IDENT_CODE, ctc_pkg::REV_CODE})
      else $error("identification word wrong");
   // lockout high threshold decode
   lockout_dec_a: assert property (@(posedge ref_clk) disable iff (rst)
      lockout_high == !lockout_reg[ctc_pkg::LOCK_HI_BIT])
      else $error("lockout decode wrong");
   // defaults and idle outputs at the first edge after reset release
   reset_val_a: assert property (@(posedge ref_clk)
      ($past(rst) && !rst) |-> offset_reg == ctc_pkg::OFFSET_RST &&
         pgtrk_reg == ctc_pkg::PGTRK_RST && lockout_reg == ctc_pkg::LOCKOUT_RST &&
         !rvalid && rdata == 16'h0000 && !switch_enable)
      else $error("reset defaults wrong");
   // write to lockout lands next cycle
   lockout_write_a: assert property (@(posedge ref_clk) disable iff (rst)
      (clk_en && req.wr && hit_lock) |=>
         lockout_reg == ($past(req.wdata) & ctc_pkg::LOCKOUT_MASK))
      else $error("lockout write lost");
   // write to power-good/tracking lands next cycle
   pgtrk_write_a: assert property (@(posedge ref_clk) disable iff (rst)
      (clk_en && req.wr && hit_pg) |=>
         pgtrk_reg == ($past(req.wdata) & ctc_pkg::PGTRK_MASK))
      else $error("power-good write lost");
   // writes to the identification word or unmapped codes change nothing
   ident_ro_a: assert property (@(posedge ref_clk) disable iff (rst)
      (clk_en && req.wr && !(hit_ofs || hit_lock || hit_pg)) |=>
         $stable(offset_reg) && $stable(lockout_reg) && $stable(pgtrk_reg))
      else $error("read-only or unmapped write changed a register");
   // low clock enable freezes settings and outputs
   freeze_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
      !clk_en |=> $stable(offset_reg) && $stable(lockout_reg) && $stable(pgtrk_reg) &&
         $stable(cfg) && $stable(rvalid) && $stable(rdata))
      else $error("state moved while clock enable low");
   // unmapped read answers zero
   unmapped_read_a: assert property (@(posedge ref_clk) disable iff (rst)
      (clk_en && req.rd && !hit_any) |=> rvalid && rdata == 16'h0000)
      else $error("unmapped read not zero");
   // byte registers read with upper byte clear
   upper_zero_a: assert property (@(posedge ref_clk) disable iff (rst)
      (clk_en && req.rd && (hit_ofs || hit_lock || hit_pg)) |=> rdata[15:8] == 8'h00)
      else $error("upper read byte not zero");
   // read data holds between reads
   rdata_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
      (clk_en && !req.rd) |=> !rvalid && $stable(rdata))
      else $error("read data moved without a read");
   // option set lets a request through regardless of tracking
   gate_open_a: assert property (@(posedge ref_clk) disable iff (rst)
      (clk_en && switch_request && pgtrk_reg[ctc_pkg::TRK_GATE_BIT]) |=> switch_enable)
      else $error("gate option ignored");
   // power-good window output follows its bit
   window_follow_a: assert property (@(posedge ref_clk) disable iff (rst)
      cfg.power_good_window_select == pgtrk_reg[ctc_pkg::PG_WIN_BIT])
      else $error("window select differs from stored bit");
   // manual trim value in mV
   trim_value_a: assert property (@(posedge ref_clk) disable iff (rst)
      !offset_reg[ctc_pkg::OFS_SEL_BIT] |->
         trim_mv_steps == {offset_reg[ctc_pkg::OFS_TRIM_LSB +: 2], 1'b0})
      else $error("manual trim value wrong");
   // lockout field output follows its bits
   lockout_field_a: assert property (@(posedge ref_clk) disable iff (rst)
      cfg.bias_lockout_level == lockout_reg[ctc_pkg::LOCK_LSB +: 3])
      else $error("lockout level differs from stored bits");
   // gate option output follows its bit
   gate_field_a: assert property (@(posedge ref_clk) disable iff (rst)
      cfg.track_gate_option == pgtrk_reg[ctc_pkg::TRK_GATE_BIT])
      else $error("gate option differs from stored bit");
   // second sync stage reads only the first
   sync_delay_a: assert property (@(posedge ref_clk) disable iff (rst)
      clk_en |=> tok_sync_reg == $past(tok_meta_reg))
      else $error("tracking ok synchroniser skipped a stage");
   // no request, no switching
   switch_drop_a: assert property (@(posedge ref_clk) disable iff (rst)
      (clk_en && !switch_request) |=> !switch_enable)
      else $error("switching without request");
   // offset register only moves on its own write
   offset_keep_a: assert property (@(posedge ref_clk) disable iff (rst)
      !(clk_en && req.wr && hit_ofs) |=> $stable(offset_reg))
      else $error("offset register moved without a write");
   // reads leave the settings alone
   read_no_write_a: assert property (@(posedge ref_clk) disable iff (rst)
      (clk_en && req.rd && !req.wr) |=>
         $stable(offset_reg) && $stable(lockout_reg) && $stable(pgtrk_reg))
      else $error("read changed a register");
   // tracking target output follows its bits
   target_follow_a: assert property (@(posedge ref_clk) disable iff (rst)
      cfg.track_target_code == pgtrk_reg[ctc_pkg::TRK_TGT_LSB +: 4])
      else $error("tracking target differs from stored bits");
   // scheme and trim code outputs follow their bits
   scheme_follow_a: assert property (@(posedge ref_clk) disable iff (rst)
      cfg.offset_scheme_select == offset_reg[ctc_pkg::OFS_SEL_BIT] &&
      cfg.offset_trim_code == offset_reg[ctc_pkg::OFS_TRIM_LSB +: 2])
      else $error("offset fields differ from stored bits");
endmodule

// [tb/ctc_host.sv]
// host-side model issuing management bus writes and reads
`timescale 1ns/1ns
module ctc_host (
   input wire logic ref_clk,
   output ctc_pkg::ctc_req_s req,
   input wire logic rvalid,
   input wire logic [15:0] rdata
);
   initial req = '0;
   // one-cycle write strobe, driven on falling edges
   task automatic wr(input logic [7:0] c, input logic [7:0] d);
      @(negedge ref_clk) req = '{wr: 1'b1, rd: 1'b0, cmd: c, wdata: d};
      @(negedge ref_clk) req = '0;
   endtask
   // no answer in the next cycle yields unknown, so a silent design fails
   task automatic rd(input logic [7:0] c, output logic [15:0] q);
      @(negedge ref_clk) req = '{wr: 1'b0, rd: 1'b1, cmd: c, wdata: 8'h00};
      @(negedge ref_clk) req = '0;
      q = rvalid ? rdata : 16'hxxxx;
   endtask
endmodule

// [tb/tb_top.sv]
// self-checking bench for the converter trim configuration bank
`timescale 1ns/1ns
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin \
   $display("CHECK FAILED %s exp %h got %h", n, e, a); error_cnt++; end end
module tb_top;
   logic ref_clk = 0, rst = 1, trk_ok = 0, sw_req = 0, clk_en = 1;
   ctc_pkg::ctc_req_s req;
   logic [15:0] rdata, q;
   logic rvalid, lockout_high, switch_enable;
   logic [2:0] trim;
   ctc_pkg::ctc_cfg_s cfg;
   int error_cnt = 0, comparisons = 0;
   typedef struct {logic [7:0] cmd; logic [7:0] wd; logic [15:0] exp;} ctc_row_s;
   // write a value, read it back; reserved bits must come back clear
   ctc_row_s rows[8] = '{'{8'hd4, 8'hff, 16'h00e0}, '{8'hd4, 8'h60, 16'h0060},
      '{8'hd6, 8'hff, 16'h0007}, '{8'hd6, 8'h03, 16'h0003}, '{8'hd7, 8'hff, 16'h00df},
      '{8'hd7, 8'h00, 16'h0000}, '{8'hfc, 8'hff, {ctc_pkg::IDENT_CODE, ctc_pkg::REV_CODE}},
      '{8'h55, 8'h12, 16'h0000}};
   logic [7:0] rcmd[3] = '{8'hd4, 8'hd6, 8'hd7};
   logic [15:0] rexp[3] = '{16'h0080, 16'h0005, 16'h008f};
   ctc_regs dut (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .req(req),
      .tracking_input_ok(trk_ok), .switch_request(sw_req), .rdata(rdata), .rvalid(rvalid),
      .cfg(cfg), .trim_mv_steps(trim), .lockout_high(lockout_high),
      .switch_enable(switch_enable));
   ctc_host host (.ref_clk(ref_clk), .req(req), .rvalid(rvalid), .rdata(rdata));
   initial forever #2 ref_clk = ~ref_clk;
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // watchdog, far beyond the roughly 70 cycles the tests need
   initial begin
      #20000;
      error_cnt++;
      summarize();
   end
   initial begin
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk) rst = 0;
      repeat (2) @(negedge ref_clk);
      `CHK("cfg reset", 13'h12cf, cfg)
      `CHK("trim auto", 3'h0, trim)
      `CHK("lockout reset", 1'b0, lockout_high)
      for (int i = 0; i < 3; i++) begin
         host.rd(rcmd[i], q);
         `CHK("reset read", rexp[i], q)
      end
      $display("reset test done");
      foreach (rows[i]) begin
         host.wr(rows[i].cmd, rows[i].wd);
         host.rd(rows[i].cmd, q);
         `CHK("readback", rows[i].exp, q)
         $display("row %0d done", i);
      end
      // state now: manual scheme trim 3, lockout 011, gate option 0
      `CHK("trim manual", 3'h6, trim)
      `CHK("lockout high", 1'b1, lockout_high)
      sw_req = 1;
      repeat (5) @(negedge ref_clk);
      `CHK("gate blocks", 1'b0, switch_enable)
      trk_ok = 1;
      repeat (5) @(negedge ref_clk);
      `CHK("gate opens", 1'b1, switch_enable)
      trk_ok = 0;
      host.wr(8'hd7, 8'h50);
      repeat (5) @(negedge ref_clk);
      `CHK("spare out", 1'b1, cfg.spare_output)
      `CHK("gate ignored", 1'b1, switch_enable)
      `CHK("cfg fields", 13'h0db0, cfg)
      $display("gating test done");
      // frozen clock enable: a write must not land and outputs must hold
      clk_en = 0;
      host.wr(8'hd4, 8'h80);
      repeat (2) @(negedge ref_clk);
      `CHK("freeze cfg", 1'b0, cfg.offset_scheme_select)
      clk_en = 1;
      host.rd(8'hd4, q);
      `CHK("freeze write", 16'h0060, q)
      $display("clock enable test done");
      rst = 1;
      @(negedge ref_clk) rst = 0;
      host.rd(8'hd7, q);
      `CHK("mid reset", 16'h008f, q)
      `CHK("mid reset cfg", 13'h12cf, cfg)
      `CHK("mid reset gate", 1'b0, switch_enable)
      $display("mid-run reset test done");
      summarize();
   end
endmodule
